// file: logic/i2csam_top.sv
// I2C slave address recognition: masked compare, general call, address hold.
// Assumes scl/sda pins are asynchronous and run far slower than clk.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "i2csam_cfg.svh"
module i2csam_top #(
  parameter int ADDR_W = 4
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   scl_out,
  output logic                   scl_oe,
  output logic                   sda_out,
  output logic                   sda_oe,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  output logic                   irq
);
  // ****************************************
  // Parameter check
  // ****************************************
  initial
  begin
    if (ADDR_W < 3)
      $error("ADDR_W too small for register map");
  end

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  logic [1:0] scl_sync;     // Two-flop synchroniser for scl
  logic [1:0] sda_sync;     // Two-flop synchroniser for sda
  logic       scl_q;        // Previous synchronised scl
  logic       sda_q;        // Previous synchronised sda
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;

  // Only the second flop of each pair feeds logic
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  assign scl_rise   = scl_sync[1] & ~scl_q;
  assign scl_fall   = ~scl_sync[1] & scl_q;
  // Start/stop: sda moves while scl stays high
  assign start_cond = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  assign stop_cond  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

  // ****************************************
  // Software registers
  // ****************************************
  logic [7:0] control_reg;      // Enables and ack value
  logic [7:0] own_address_reg;  // Stored own address
  logic [7:0] address_mask_reg; // Per-bit compare mask
  logic [7:0] receive_buffer;   // Last byte received
  logic [3:0] irq_status;       // Sticky events
  logic [3:0] irq_mask;         // Event enables
  logic [3:0] irq_set;          // Events this cycle
  logic       release_pulse;    // Software clock release

  logic general_call_enable;
  logic address_hold_enable;
  logic ten_bit_mode;
  logic ack_value_bit;
  assign general_call_enable = control_reg[`I2CSAM_CTRL_GENERAL_CALL_ENABLE];
  assign address_hold_enable = control_reg[`I2CSAM_CTRL_ADDRESS_HOLD_ENABLE];
  assign ten_bit_mode        = control_reg[`I2CSAM_CTRL_TENBIT];
  assign ack_value_bit       = control_reg[`I2CSAM_CTRL_ACK_VALUE_BIT];

  // Config writes
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      control_reg      <= 8'h00;
      own_address_reg  <= 8'h00;
      address_mask_reg <= `I2CSAM_MASK_RST;
      irq_mask         <= 4'h0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `I2CSAM_OFF_CTRL:   control_reg      <= reg_wdata;
        `I2CSAM_OFF_OWN:    own_address_reg  <= reg_wdata;
        `I2CSAM_OFF_MASK:   address_mask_reg <= reg_wdata;
        `I2CSAM_OFF_IRQMSK: irq_mask         <= reg_wdata[3:0];
        default:            ;
      endcase
    end
  end

  assign release_pulse = reg_wr && (reg_addr == ADDR_W'(`I2CSAM_OFF_RELEASE));

  // Sticky status: set wins over write-one-to-clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_status <= 4'h0;
    else if (reg_wr && reg_addr == ADDR_W'(`I2CSAM_OFF_STAT))
      irq_status <= (irq_status & ~reg_wdata[3:0]) | irq_set;
    else
      irq_status <= irq_status | irq_set;
  end

  // Registered level interrupt from status and this cycle's events
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(((irq_status | irq_set)) & irq_mask);
  end

  // ****************************************
  // Address compare
  // ****************************************
  // Masked compare; zero mask bit is a don't care
  function automatic logic masked_eq(input logic [7:0] rx,
                                     input logic [7:0] own,
                                     input logic [7:0] msk);
    masked_eq = ((rx ^ own) & msk) == 8'h00;
  endfunction

  logic [7:0] receive_shift_reg; // Incoming bits, msb first
  logic [3:0] bit_cnt;           // Bits clocked this byte
  logic       byte_idx;          // Second address byte pending
  logic       update_address_flag;
  logic       addr_hit;
  logic       gcall_hit;
  logic       hi_hit;

  // 7-bit compares A<7:1>, the r/w bit is ignored
  // 10-bit header byte exact, low byte masked on A<7:0>
  always_comb
  begin
    gcall_hit = general_call_enable &&
                receive_shift_reg == `I2CSAM_GCALL_ADDR;
    hi_hit    = receive_shift_reg[7:3] == `I2CSAM_TENBIT_HDR &&
                receive_shift_reg[2:1] == own_address_reg[2:1];
    if (ten_bit_mode && byte_idx)
      addr_hit = masked_eq(receive_shift_reg, own_address_reg,
                           address_mask_reg);
    else if (ten_bit_mode)
      addr_hit = hi_hit;
    else
      addr_hit = masked_eq({receive_shift_reg[7:1], 1'b0},
                           {own_address_reg[7:1], 1'b0},
                           {address_mask_reg[7:1], 1'b0});
  end

  // ****************************************
  // Byte state machine
  // ****************************************
  i2csam_pkg::i2csam_state_t state;
  logic do_ack;    // Ack chosen for this byte
  logic is_gcall;  // Current byte hit general call

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state               <= i2csam_pkg::I2CSAM_IDLE;
      receive_shift_reg   <= 8'h00;
      bit_cnt             <= 4'h0;
      byte_idx            <= 1'b0;
      update_address_flag <= 1'b0;
      receive_buffer      <= 8'h00;
      do_ack              <= 1'b0;
      is_gcall            <= 1'b0;
    end
    else if (stop_cond)
      state <= i2csam_pkg::I2CSAM_IDLE;
    else if (start_cond)
    begin
      state    <= i2csam_pkg::I2CSAM_ADDR;
      bit_cnt  <= 4'h0;
      byte_idx <= 1'b0;
    end
    else
    begin
      unique case (state)
        i2csam_pkg::I2CSAM_IDLE: ;
        i2csam_pkg::I2CSAM_ADDR, i2csam_pkg::I2CSAM_DATA:
        begin
          if (scl_rise && bit_cnt != `I2CSAM_BITS_BYTE)
          begin
            receive_shift_reg <= {receive_shift_reg[6:0], sda_sync[1]};
            bit_cnt           <= bit_cnt + 4'h1;
          end
          // Eighth falling edge ends the byte
          if (scl_fall && bit_cnt == `I2CSAM_BITS_BYTE)
          begin
            bit_cnt        <= 4'h0;
            receive_buffer <= receive_shift_reg;
            if (state == i2csam_pkg::I2CSAM_DATA)
            begin
              do_ack <= 1'b1;
              state  <= i2csam_pkg::I2CSAM_ACK;
            end
            else if (gcall_hit || addr_hit)
            begin
              is_gcall <= gcall_hit;
              // UA only for a real 10-bit address, never general call
              update_address_flag <= ten_bit_mode && !gcall_hit;
              if (address_hold_enable)
                state <= i2csam_pkg::I2CSAM_HOLD;
              else
              begin
                do_ack <= 1'b1;
                state  <= i2csam_pkg::I2CSAM_ACK;
              end
            end
            else
              state <= i2csam_pkg::I2CSAM_IDLE;
          end
        end
        i2csam_pkg::I2CSAM_HOLD:
        begin
          // Clock held low until software releases it
          if (release_pulse)
          begin
            do_ack <= !ack_value_bit;
            state  <= i2csam_pkg::I2CSAM_ACK;
          end
        end
        i2csam_pkg::I2CSAM_ACK:
        begin
          if (scl_fall)
          begin
            update_address_flag <= 1'b0;
            // Ten-bit low byte still owed unless general call
            if (!do_ack)
              state <= i2csam_pkg::I2CSAM_IDLE;
            else if (ten_bit_mode && !byte_idx && !is_gcall)
            begin
              byte_idx <= 1'b1;
              state    <= i2csam_pkg::I2CSAM_ADDR;
            end
            else
              state <= i2csam_pkg::I2CSAM_DATA;
          end
        end
      endcase
    end
  end

  // Events: address match, general call write, data byte, UA
  logic byte_done;
  assign byte_done = scl_fall && bit_cnt == `I2CSAM_BITS_BYTE;
  always_comb
  begin
    irq_set = 4'h0;
    if (byte_done && state == i2csam_pkg::I2CSAM_ADDR)
    begin
      irq_set[`I2CSAM_ST_ADDR]  = addr_hit && !gcall_hit;
      irq_set[`I2CSAM_ST_GCALL] = gcall_hit && !receive_shift_reg[0];
      irq_set[`I2CSAM_ST_UA]    = ten_bit_mode && addr_hit && !gcall_hit;
    end
    if (byte_done && state == i2csam_pkg::I2CSAM_DATA)
      irq_set[`I2CSAM_ST_DATA] = 1'b1;
  end

  // ****************************************
  // Pin drivers and read port
  // ****************************************
  // Open drain: drive low only, enable high while driving
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end
    else
    begin
      // The stretch ends on the release edge, a cycle before the ack drive, so after a hold
      // data falls while the clock is high (that would read as a start)
      scl_oe <= ((state == i2csam_pkg::I2CSAM_HOLD) && !release_pulse) ||
                ((state == i2csam_pkg::I2CSAM_ACK) && scl_oe && do_ack &&
                 !sda_oe);
      sda_oe <= (state == i2csam_pkg::I2CSAM_ACK) && do_ack;
    end
  end

  // Read data one cycle after strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `I2CSAM_OFF_CTRL:   reg_rdata <= control_reg;
        `I2CSAM_OFF_OWN:    reg_rdata <= own_address_reg;
        `I2CSAM_OFF_MASK:   reg_rdata <= address_mask_reg;
        `I2CSAM_OFF_RXBUF:  reg_rdata <= receive_buffer;
        `I2CSAM_OFF_STAT:   reg_rdata <= {3'h0, update_address_flag, irq_status};
        `I2CSAM_OFF_IRQMSK: reg_rdata <= {4'h0, irq_mask};
        default:            reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_hold_byte;
    byte_done && state == i2csam_pkg::I2CSAM_ADDR && address_hold_enable
      && (addr_hit || gcall_hit) && !stop_cond && !start_cond;
  endsequence

  chk_hold_stretch: assert property (@(posedge clk) disable iff (!rst_b)
    s_hold_byte |=> ##1 scl_oe)
    else $error("clock not stretched after address");
  chk_hold_until_release: assert property (@(posedge clk) disable iff (!rst_b)
    (state == i2csam_pkg::I2CSAM_HOLD && !release_pulse && !stop_cond)
      |=> scl_oe)
    else $error("stretch ended without release");
  chk_mask_reset: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> address_mask_reg == `I2CSAM_MASK_RST)
    else $error("mask not all ones after reset");
  chk_gcall_irq: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_done && state == i2csam_pkg::I2CSAM_ADDR && gcall_hit
      && !receive_shift_reg[0] && !stop_cond && !start_cond)
      |=> irq_status[`I2CSAM_ST_GCALL] && receive_buffer == 8'h00)
    else $error("general call not flagged");
  chk_gcall_no_ua: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_done && state == i2csam_pkg::I2CSAM_ADDR && gcall_hit
      && !stop_cond && !start_cond) |=> !update_address_flag)
    else $error("update flag set on general call");
  chk_gcall_ack: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_done && state == i2csam_pkg::I2CSAM_ADDR && gcall_hit
      && !address_hold_enable && !stop_cond && !start_cond)
      |=> ##1 sda_oe)
    else $error("general call not acked");
  chk_no_match_idle: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_done && state == i2csam_pkg::I2CSAM_ADDR && !addr_hit
      && !gcall_hit && !stop_cond && !start_cond)
      |=> state == i2csam_pkg::I2CSAM_IDLE)
    else $error("mismatch not ignored");
  chk_seven_mask: assert property (@(posedge clk) disable iff (!rst_b)
    (!ten_bit_mode && ((receive_shift_reg ^ own_address_reg)
      & address_mask_reg & 8'hfe) == 8'h00) |-> addr_hit)
    else $error("masked seven-bit compare wrong");
endmodule // i2csam_top
`default_nettype wire

// file: logic/i2csam_cfg.svh
// Constants for the I2C slave address matcher.
// Assumes inclusion by bare name from the design file.
`ifndef I2CSAM_CFG_SVH
`define I2CSAM_CFG_SVH
// Register offsets on the plain register port
`define I2CSAM_OFF_CTRL    4'h0
`define I2CSAM_OFF_OWN     4'h1
`define I2CSAM_OFF_MASK    4'h2
`define I2CSAM_OFF_RXBUF   4'h3
`define I2CSAM_OFF_STAT    4'h4
`define I2CSAM_OFF_IRQMSK  4'h5
`define I2CSAM_OFF_RELEASE 4'h6
// Control register field positions
`define I2CSAM_CTRL_GENERAL_CALL_ENABLE   0
`define I2CSAM_CTRL_ADDRESS_HOLD_ENABLE   1
`define I2CSAM_CTRL_TENBIT 2
`define I2CSAM_CTRL_ACK_VALUE_BIT  3
// Status / interrupt bit positions
`define I2CSAM_ST_ADDR     0
`define I2CSAM_ST_GCALL    1
`define I2CSAM_ST_DATA     2
`define I2CSAM_ST_UA       3
// Reset value and protocol constants
`define I2CSAM_MASK_RST    8'hff
`define I2CSAM_GCALL_ADDR  8'h00
`define I2CSAM_TENBIT_HDR  5'h1e
`define I2CSAM_BITS_BYTE   4'h8
`endif

// file: logic/i2csam_pkg.sv
// Types for the I2C slave address matcher.
// Assumes the constants header sits beside it.
package i2csam_pkg;
  // Byte phase of the slave receiver
  typedef enum logic [4:0] {
    I2CSAM_IDLE  = 5'b00001,
    I2CSAM_ADDR  = 5'b00010,
    I2CSAM_HOLD  = 5'b00100,
    I2CSAM_ACK   = 5'b01000,
    I2CSAM_DATA  = 5'b10000
  } i2csam_state_t;
endpackage

// file: verif/i2csam_master_model.sv
// Behavioural I2C master that addresses the slave under test.
// Assumes open-drain lines with pull-ups and an 80 ns bit time.
`timescale 1ns/1ps
`default_nettype none
module i2csam_master_model (
  input  wire logic scl_oe,    // Slave stretches clock
  input  wire logic sda_oe,    // Slave pulls data low
  output logic      scl,       // Resolved clock line
  output logic      sda,       // Resolved data line
  output logic      ack_valid, // Pulse when ack sampled
  output logic      ack_bit    // One when slave acked
);
  // ****************
  // Line drivers
  // ****************
  logic scl_low = 1'b0; // Master pulls clock low
  logic sda_low = 1'b0; // Master pulls data low
  // Pull-ups win unless a party drives low
  assign scl = ~(scl_low | scl_oe);
  assign sda = ~(sda_low | sda_oe);
  initial ack_valid = 1'b0;
  initial ack_bit = 1'b0;
  // Start: data falls while clock is high
  task automatic start_cond();
    sda_low = 1'b1;
    #20;
    scl_low = 1'b1;
  endtask
  // Stop: data rises while clock is high
  task automatic stop_cond();
    #20;
    sda_low = 1'b1;
    #20;
    scl_low = 1'b0;
    #20;
    sda_low = 1'b0;
    #40;
  endtask
  // Eight bits msb first, then the ack slot
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= -1; i--)
    begin
      #20;
      sda_low = (i >= 0) ? ~b[i] : 1'b0;
      // Late release in ack slot so a stretch is not missed
      #((i < 0) ? 60 : 20);
      scl_low = 1'b0;
      // Honour clock stretching, but never hang
      for (int w = 0; w < 5000 && !scl; w++)
        #8;
      #20;
      if (i < 0)
      begin
        ack_bit = ~sda;
        ack_valid = 1'b1;
      end
      #20;
      scl_low = 1'b1;
      ack_valid = 1'b0;
    end
  endtask
endmodule // i2csam_master_model
`default_nettype wire

// file: verif/i2csam_top_tb_top.sv
// Bench: masked match, general call, ten-bit, address hold.
// Assumes the master model is compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module i2csam_top_tb_top;
  // ****************
  // Signals
  // ****************
  logic        clk;            // System clock
  logic        rst_b;          // Reset, active low
  logic        scl;            // Resolved clock line
  logic        sda;            // Resolved data line
  logic        scl_oe;         // Slave stretch
  logic        sda_oe;         // Slave ack
  logic [3:0]  reg_addr;       // Register index
  logic [7:0]  reg_wdata;      // Write data
  logic        reg_wr;         // Write strobe
  logic        reg_rd;         // Read strobe
  logic [7:0]  reg_rdata;      // Read data
  logic        irq;            // Interrupt level
  logic        ack_valid;      // Ack sampled by master
  logic        ack_bit;        // Ack value
  logic        rd_d = 1'b0;    // Read taken last edge
  logic [15:0] e_rd;           // Popped read note
  logic [15:0] exp_rd[$];      // Notes {care, data}
  logic        exp_ack[$];     // Expected acks
  logic [31:0] seed;           // LFSR state
  logic [7:0]  own;            // Own address
  logic [7:0]  msk;            // Mask
  logic [7:0]  adr;            // Address sent
  logic        hit;            // Expected match
  int          fail_count;     // Mismatches
  int          n_checks;       // Comparisons
  i2csam_top #(.ADDR_W(4)) uut (
    .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
    .scl_out(), .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  i2csam_master_model mdl (
    .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda),
    .ack_valid(ack_valid), .ack_bit(ack_bit));
  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Gap cycle after each strobe keeps one assignment per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Extra edge so registered irq reflects the write when checked
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    exp_rd.push_back({m, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic xfer(input logic [7:0] b, input logic e);
    exp_ack.push_back(e);
    mdl.send_byte(b);
  endtask
  // Stop, then realign to the clock
  task automatic fin();
    mdl.stop_cond();
    repeat (8) @(posedge clk);
  endtask
  task automatic frame(input logic [7:0] a, input logic e);
    mdl.start_cond();
    xfer(a, e);
    fin();
  endtask
  task automatic test_done();
    $display("checks=%0d failures=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****************
  // Monitors
  // ****************
  // Read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rd_d)
    begin
      e_rd = exp_rd.pop_front();
      check(reg_rdata & e_rd[15:8], e_rd[7:0]);
    end
    rd_d <= reg_rd;
  end
  always @(posedge ack_valid)
    check({7'h0, ack_bit}, {7'h0, exp_ack.pop_front()});
  // ****************
  // Stimulus
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Watchdog, far beyond the expected run
  initial
  begin
    #200000;
    fail_count++;
    test_done();
  end
  initial
  begin
    {rst_b, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {fail_count, n_checks} = '0;
    seed = 32'h5ac668fb;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(4'h2, 8'hff, 8'hff);
    rd(4'h7, 8'hff, 8'h00);
    wr(4'h5, 8'h0f);
    // Random own address, mask and near-miss addresses
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      own = seed[7:0] & 8'hfe;
      msk = seed[15:8];
      adr = own ^ (seed[23:16] & seed[31:24] & 8'hfe);
      hit = ((adr ^ own) & msk & 8'hfe) == 8'h00;
      wr(4'h1, own);
      wr(4'h2, msk);
      frame(adr, hit);
      check({7'h0, irq}, {7'h0, hit});
      wr(4'h4, 8'hff);
      check({7'h0, irq}, 8'h00);
    end
    // Zero without enable is an ordinary compare; irq masked
    wr(4'h1, 8'h50);
    wr(4'h2, 8'hff);
    frame(8'h00, 1'b0);
    wr(4'h5, 8'h02);
    frame(8'h50, 1'b1);
    check({7'h0, irq}, 8'h00);
    wr(4'h4, 8'hff);
    // General call with a data byte
    wr(4'h0, 8'h01);
    mdl.start_cond();
    xfer(8'h00, 1'b1);
    xfer(8'ha5, 1'b1);
    fin();
    check({7'h0, irq}, 8'h01);
    rd(4'h3, 8'hff, 8'ha5);
    rd(4'h4, 8'h06, 8'h06);
    wr(4'h4, 8'hff);
    // Ten-bit mode general call: next byte is data, no update flag
    wr(4'h0, 8'h05);
    mdl.start_cond();
    xfer(8'h00, 1'b1);
    xfer(8'h3c, 1'b1);
    fin();
    rd(4'h4, 8'h1c, 8'h04);
    rd(4'h3, 8'hff, 8'h3c);
    wr(4'h4, 8'hff);
    // Ten-bit address: exact header, masked low byte, UA event
    wr(4'h0, 8'h04);
    wr(4'h2, 8'h00);
    frame(8'hf2, 1'b0);
    mdl.start_cond();
    xfer(8'hf0, 1'b1);
    xfer(8'h3a, 1'b1);
    fin();
    rd(4'h4, 8'h08, 8'h08);
    wr(4'h2, 8'hff);
    wr(4'h4, 8'hff);
    // Address hold: software picks ack, then releases
    for (int k = 0; k < 2; k++)
    begin
      wr(4'h0, 8'h03);
      mdl.start_cond();
      exp_ack.push_back(k == 0);
      fork
        mdl.send_byte((k == 0) ? 8'h50 : 8'h00);
        begin
          for (int i = 0; i < 400 && !scl_oe; i++)
            @(posedge clk);
          repeat (40) @(posedge clk);
          check({7'h0, scl_oe}, 8'h01);
          check({7'h0, scl}, 8'h00);
          wr(4'h0, (k == 0) ? 8'h03 : 8'h0b);
          wr(4'h6, 8'h00);
        end
      join
      fin();
    end
    test_done();
  end
endmodule // i2csam_top_tb_top
`default_nettype wire
